// File: shared/sbsc_pkg.sv
// Shared constants and carrier types for the synchronous burst SRAM cycle control
package sbsc_pkg;
    // ==========================================================
    // Geometry
    localparam int SBSC_ADDR_W = 15;   // 32K words
    localparam int SBSC_LANES = 4;     // Byte lanes per word
    localparam int SBSC_LANE_W = 9;    // Eight data bits plus parity bit
    localparam int SBSC_WORD_W = 36;   // Full word width
    localparam int SBSC_BURST_W = 2;   // Burst counter width
    localparam logic [1:0] SBSC_BURST_RST = 2'h0;  // Burst counter after reset

    // ==========================================================
    // Synchronous inputs sampled at each edge
    typedef struct packed {
        logic processor_address_strobe_n;
        logic controller_address_strobe_n;
        logic burst_step_n;
        logic [3:0] byte_write_n;       // Lane 3 in bit 3
        logic primary_select_n;
        logic secondary_select;
        logic secondary_select_n;
        logic [14:0] addr;
        logic [35:0] wdata;
    } sbsc_sample_t;

    // Cycle kinds
    typedef enum logic [2:0] {
        SBSC_IDLE = 3'h1,
        SBSC_READ = 3'h2,
        SBSC_WRITE = 3'h4
    } sbsc_cycle_t;
endpackage

// File: logic/sbsc_mem.sv
// Byte-lane write-masked word array with registered read data
`timescale 1ns/1ns
`default_nettype none
module sbsc_mem
    import sbsc_pkg::*;
#(
    parameter int ADDR_W = SBSC_ADDR_W,
    parameter int LANES = SBSC_LANES,
    parameter int LANE_W = SBSC_LANE_W
) (
    // Clock
    input wire logic sys_clk,
    // Access port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] lane_we,
    input wire logic [LANES*LANE_W-1:0] wdata,
    output logic [LANES*LANE_W-1:0] rdata
);
    // ==========================================================
    // One array per lane, so each process owns its own storage
    // Untouched lanes keep their contents
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];  // Storage of this lane
            // Registered read; a write in the same edge shows old data
            always_ff @(posedge sys_clk) begin
                if (lane_we[g]) begin
                    lane_mem[addr] <= wdata[g*LANE_W +: LANE_W];
                end
                rdata[g*LANE_W +: LANE_W] <= lane_mem[addr];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: logic/sbsc_burst.sv
// Two-bit interleaved burst address generator
`timescale 1ns/1ns
`default_nettype none
module sbsc_burst
    import sbsc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic step,
    // Low bits of the current address
    input wire logic [1:0] base,
    output logic [1:0] offset
);
    // Count of steps taken since the load
    logic [1:0] count;
    logic [1:0] next_count;
    logic [1:0] start;
    logic [1:0] next_start;

    // Next-state: load clears the count, step advances it
    always_comb begin
        next_count = count;
        next_start = start;
        if (load) begin
            next_count = SBSC_BURST_RST;
            next_start = base;
        end else if (step) begin
            next_count = count + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= SBSC_BURST_RST;
            start <= SBSC_BURST_RST;
        end else begin
            count <= next_count;
            start <= next_start;
        end
    end

    // Interleaved order: start xor count, wraps inside the group
    assign offset = start ^ count;
endmodule
`default_nettype wire

// File: logic/sbsc_core.sv
// Cycle control of a 32K x 36 pipelined synchronous burst SRAM
// ==========================================================
// What this block does
// - Read when no lane enabled or processor strobe
// - Write needs lane enable and processor strobe high
// - Output enable ignored when a lane write sampled
// - Capture address when a strobe low and selected
// - Chip enables evaluated on strobe edges
// - Deselect enters power-down; active otherwise
// - Burst continues from internal counter address
// - Select needs primary low, secondary high and secondary_select_n low
// - Write to loaded address needs burst step high
// - Parity drivers off when parity output disabled
// - Extra enables allow two-device depth expansion
`timescale 1ns/1ns
`default_nettype none
module sbsc_core
    import sbsc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Synchronous bus inputs, raw from pins
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic burst_step_n,
    input wire logic byte_lane0_write_n,
    input wire logic byte_lane1_write_n,
    input wire logic byte_lane2_write_n,
    input wire logic byte_lane3_write_n,
    input wire logic primary_select_n,
    input wire logic secondary_select,
    input wire logic secondary_select_n,
    input wire logic [SBSC_ADDR_W-1:0] addr,
    input wire logic [SBSC_WORD_W-1:0] data_in,
    // Asynchronous controls
    input wire logic output_enable_n,
    input wire logic parity_output_off,
    // Data outputs; enables low while driving
    output logic [31:0] data_out,
    output logic [31:0] data_oe_n,
    output logic [3:0] parity_out,
    output logic [3:0] parity_oe_n,
    // Status
    output logic active,
    output logic write_done
);
    // ==========================================================
    // Pin synchronisers: two stages before any logic reads them
    sbsc_sample_t pin_now;
    sbsc_sample_t sync1;
    sbsc_sample_t smp;
    logic [1:0] oe_sync;       // Output enable, two stages
    logic [1:0] poff_sync;     // Parity disable, two stages

    always_comb begin
        pin_now.processor_address_strobe_n = processor_address_strobe_n;
        pin_now.controller_address_strobe_n = controller_address_strobe_n;
        pin_now.burst_step_n = burst_step_n;
        pin_now.byte_write_n = {byte_lane3_write_n, byte_lane2_write_n,
                                byte_lane1_write_n, byte_lane0_write_n};
        pin_now.primary_select_n = primary_select_n;
        pin_now.secondary_select = secondary_select;
        pin_now.secondary_select_n = secondary_select_n;
        pin_now.addr = addr;
        pin_now.wdata = data_in;
    end

    // Sample registers; the bus is idle-valued during reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1 <= '1;
            smp <= '1;
            oe_sync <= 2'h3;
            poff_sync <= 2'h3;
        end else begin
            sync1 <= pin_now;
            smp <= sync1;
            oe_sync <= {oe_sync[0], output_enable_n};
            poff_sync <= {poff_sync[0], parity_output_off};
        end
    end

    // ==========================================================
    // Cycle decode
    logic any_strobe;
    logic any_lane;
    logic selected;
    logic is_read;
    logic is_write;

    // Decode of the chip-enable triple, used for new selection
    function automatic logic sel_decode(input sbsc_sample_t s);
        sel_decode = !s.primary_select_n && s.secondary_select && !s.secondary_select_n;
    endfunction

    // State held between edges
    logic sel_held;            // Device selected (not power-down)
    logic [SBSC_ADDR_W-1:0] base_addr;
    sbsc_cycle_t cycle;
    logic next_sel_held;
    logic [SBSC_ADDR_W-1:0] next_base_addr;
    sbsc_cycle_t next_cycle;
    logic burst_load;
    logic burst_step;
    logic [1:0] offset;

    always_comb begin
        any_strobe = !smp.processor_address_strobe_n || !smp.controller_address_strobe_n;
        any_lane = |(~smp.byte_write_n);
        // Enables only count at strobe edges; else keep selection
        selected = any_strobe ? sel_decode(smp) : sel_held;
        // Read or write classification
        is_read = !any_lane || !smp.processor_address_strobe_n;
        is_write = any_lane && smp.processor_address_strobe_n;
    end

    // Next-state of selection, address and cycle kind
    always_comb begin
        next_sel_held = selected;           // Deselect means power-down
        next_base_addr = base_addr;
        burst_load = 1'b0;
        burst_step = 1'b0;
        next_cycle = SBSC_IDLE;
        if (selected) begin
            if (any_strobe) begin
                // Fresh address at every strobe edge while selected
                next_base_addr = smp.addr;
                burst_load = 1'b1;
            end else if (!smp.burst_step_n) begin
                // Continue burst from internal counter
                burst_step = 1'b1;
            end
            // A write lands on the loaded word only with step high
            if (is_write && !(any_strobe && !smp.burst_step_n)) begin
                next_cycle = SBSC_WRITE;
            end else if (is_read) begin
                next_cycle = SBSC_READ;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_held <= 1'b0;
            base_addr <= '0;
            cycle <= SBSC_IDLE;
        end else begin
            sel_held <= next_sel_held;
            base_addr <= next_base_addr;
            cycle <= next_cycle;
        end
    end

    // Burst counter, loaded at strobe edges, stepped by the burst input
    sbsc_burst u_burst (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(burst_load),
        .step(burst_step),
        .base(next_base_addr[1:0]),
        .offset(offset)
    );

    // ==========================================================
    // Array access
    logic [SBSC_ADDR_W-1:0] word_addr;
    logic [SBSC_LANES-1:0] lane_we;
    logic [SBSC_WORD_W-1:0] mem_wdata;
    logic [SBSC_WORD_W-1:0] mem_rdata;
    logic [SBSC_LANES-1:0] lane_mask;   // Lane enables of the held cycle
    logic [SBSC_WORD_W-1:0] wdata_held;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lane_mask <= '0;
            wdata_held <= '0;
        end else begin
            lane_mask <= ~smp.byte_write_n;
            wdata_held <= smp.wdata;
        end
    end

    // Only lanes with an enable low are written, parity bit included
    always_comb begin
        word_addr = {base_addr[SBSC_ADDR_W-1:2], offset};
        lane_we = (cycle == SBSC_WRITE) ? lane_mask : '0;
        // Memory lanes hold {parity, byte}; repack from bus layout
        for (int i = 0; i < SBSC_LANES; i++) begin
            mem_wdata[i*SBSC_LANE_W +: SBSC_LANE_W] = {wdata_held[32+i], wdata_held[i*8 +: 8]};
        end
    end

    sbsc_mem u_mem (
        .sys_clk(sys_clk),
        .addr(word_addr),
        .lane_we(lane_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ==========================================================
    // Output stage
    logic read_pend;           // Read data appears one edge after access
    logic write_pend;          // Output enable ignored after a lane write
    logic next_read_pend;
    logic next_write_pend;
    logic [31:0] next_data_out;
    logic [31:0] next_data_oe_n;
    logic [3:0] next_parity_out;
    logic [3:0] next_parity_oe_n;
    logic drive;

    always_comb begin
        next_read_pend = (cycle == SBSC_READ);
        next_write_pend = (cycle == SBSC_WRITE) || any_lane;
        // Lane write forces drivers off whatever output enable does
        drive = read_pend && !write_pend && !oe_sync[1];
        next_data_out = data_out;
        next_parity_out = parity_out;
        for (int i = 0; i < SBSC_LANES; i++) begin
            if (read_pend) begin
                next_data_out[i*8 +: 8] = mem_rdata[i*SBSC_LANE_W +: 8];
                next_parity_out[i] = mem_rdata[i*SBSC_LANE_W + 8];
            end
        end
        next_data_oe_n = drive ? 32'h0 : 32'hFFFFFFFF;
        // Parity drivers stay off when disabled
        next_parity_oe_n = (drive && !poff_sync[1]) ? 4'h0 : 4'hF;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            read_pend <= 1'b0;
            write_pend <= 1'b0;
            data_out <= 32'h0;
            data_oe_n <= 32'hFFFFFFFF;
            parity_out <= 4'h0;
            parity_oe_n <= 4'hF;
            active <= 1'b0;
            write_done <= 1'b0;
        end else begin
            read_pend <= next_read_pend;
            write_pend <= next_write_pend;
            data_out <= next_data_out;
            data_oe_n <= next_data_oe_n;
            parity_out <= next_parity_out;
            parity_oe_n <= next_parity_oe_n;
            active <= next_sel_held;
            write_done <= (cycle == SBSC_WRITE);
        end
    end

    // ==========================================================
    // Checks
    parity_off_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        poff_sync[1] && $past(poff_sync[1]) |=> parity_oe_n == 4'hF)
        else $error("parity drivers on while disabled");

    write_no_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        write_pend |=> data_oe_n == 32'hFFFFFFFF)
        else $error("data driven after lane write");

    read_class_a: assert property (@(posedge sys_clk) disable iff (rst)
        selected && !smp.processor_address_strobe_n |=> cycle == SBSC_READ)
        else $error("processor strobe cycle not a read");

    write_class_a: assert property (@(posedge sys_clk) disable iff (rst)
        selected && is_write && smp.burst_step_n |=> cycle == SBSC_WRITE ##1 write_done)
        else $error("write cycle not performed");

    addr_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        selected && any_strobe |=> base_addr == $past(smp.addr) && offset == $past(smp.addr[1:0]))
        else $error("address not captured");

    deselect_pd_a: assert property (@(posedge sys_clk) disable iff (rst)
        any_strobe && !sel_decode(smp) |=> !active)
        else $error("device active after deselect");

    burst_next_a: assert property (@(posedge sys_clk) disable iff (rst)
        burst_step |=> offset == ($past(offset) ^ $past(offset ^ base_addr[1:0]) ^ ($past(offset ^ base_addr[1:0]) + 2'h1)))
        else $error("burst address not advanced");

    step_low_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        any_strobe && is_write && !smp.burst_step_n |=> cycle != SBSC_WRITE)
        else $error("write with burst step low");

    lane_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
        cycle == SBSC_WRITE |-> lane_we == lane_mask)
        else $error("wrong lanes written");

    no_strobe_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        !any_strobe |=> sel_held == $past(sel_held))
        else $error("selection changed without strobe");
endmodule
`default_nettype wire

// File: test/sbsc_ctrl_model.sv
// Behavioural cache controller driving the burst SRAM pins
`timescale 1ns/1ns
`default_nettype none
module sbsc_ctrl_model
    import sbsc_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Pin levels asked for by the bench
    input wire sbsc_sample_t cmd,
    input wire logic cmd_oe_n,
    // Pins toward the memory
    output sbsc_sample_t pins,
    output logic output_enable_n
);
    // ==========================================================
    // Pin drive
    logic [35:0] last_wdata = 36'h5A5A5A5A5; // Data left by the last write
    logic writing; // Some lane enable low
    assign writing = ~&cmd.byte_write_n;
    // Remember write data so released lines can show its inverse
    always @(posedge sys_clk) begin
        if (writing) begin
            last_wdata <= cmd.wdata;
        end
    end
    // Whole-cycle levels; released data never repeats the last value
    always_comb begin
        pins = cmd;
        if (!writing) begin
            pins.wdata = ~last_wdata;
        end
    end
    // Output enable parked high on writes to avoid contention
    assign output_enable_n = writing ? 1'b1 : cmd_oe_n;
endmodule
`default_nettype wire

// File: test/sync_burst_sram_cycle_control_test.sv
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/1ns
`default_nettype none
module sync_burst_sram_cycle_control_test
    import sbsc_pkg::*;
;
    // ==========================================================
    // Signals
    localparam int CYCLE_LIMIT = 3000; // Whole run needs well under this
    logic sys_clk = 1'b0; // 100 MHz
    logic rst = 1'b1;
    sbsc_sample_t cmd; // Bench request to the controller model
    sbsc_sample_t pins; // Levels on the pins
    logic cmd_oe_n = 1'b0;
    logic output_enable_n;
    logic parity_output_off = 1'b0;
    logic [31:0] data_out, data_oe_n;
    logic [3:0] parity_out, parity_oe_n;
    logic active, write_done;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    int writes_seen = 0; // Pulses of write_done
    int writes_exp = 0;
    logic [35:0] ref_mem [int]; // Expected array contents
    logic [14:0] used[$]; // Addresses holding known data
    logic [14:0] a, g;
    logic [35:0] d;

    // ==========================================================
    // Design and far side
    sbsc_ctrl_model far_end (.sys_clk(sys_clk), .cmd(cmd), .cmd_oe_n(cmd_oe_n), .pins(pins),
        .output_enable_n(output_enable_n));
    sbsc_core uut (.sys_clk(sys_clk), .rst(rst),
        .processor_address_strobe_n(pins.processor_address_strobe_n),
        .controller_address_strobe_n(pins.controller_address_strobe_n),
        .burst_step_n(pins.burst_step_n),
        .byte_lane0_write_n(pins.byte_write_n[0]), .byte_lane1_write_n(pins.byte_write_n[1]),
        .byte_lane2_write_n(pins.byte_write_n[2]), .byte_lane3_write_n(pins.byte_write_n[3]),
        .primary_select_n(pins.primary_select_n), .secondary_select(pins.secondary_select),
        .secondary_select_n(pins.secondary_select_n), .addr(pins.addr), .data_in(pins.wdata),
        .output_enable_n(output_enable_n), .parity_output_off(parity_output_off),
        .data_out(data_out), .data_oe_n(data_oe_n), .parity_out(parity_out),
        .parity_oe_n(parity_oe_n), .active(active), .write_done(write_done));

    // ==========================================================
    // Clock, pulse count and hang guard
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (write_done === 1'b1) begin
            writes_seen++;
        end
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            fails++;
            final_report();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [35:0] rnd36();
        return {4'($urandom), $urandom};
    endfunction
    // Lanes with a low enable take byte and parity bit
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
            input logic [3:0] bw_n);
        logic [35:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (!bw_n[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
                r[32+i] = nw[32+i];
            end
        end
        return r;
    endfunction
    // Interleaved order inside the aligned group of four
    function automatic logic [14:0] beat(input logic [14:0] base, input int j);
        return {base[14:2], base[1:0] ^ j[1:0]};
    endfunction
    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus cycle, changed just after an edge and sampled at the next
    task automatic drive(input logic ps_n, input logic cs_n, input logic st_n,
            input logic [3:0] bw_n, input logic [14:0] ad, input logic [35:0] dd);
        cmd.processor_address_strobe_n = ps_n;
        cmd.controller_address_strobe_n = cs_n;
        cmd.burst_step_n = st_n;
        cmd.byte_write_n = bw_n;
        cmd.addr = ad;
        cmd.wdata = dd;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle(input int n);
        cmd.processor_address_strobe_n = 1'b1;
        cmd.controller_address_strobe_n = 1'b1;
        cmd.burst_step_n = 1'b1;
        cmd.byte_write_n = 4'hF;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [14:0] ad, input logic [35:0] dd, input logic [3:0] bw_n);
        drive(1'b1, 1'b0, 1'b1, bw_n, ad, dd);
        ref_mem[ad] = merge(ref_mem.exists(ad) ? ref_mem[ad] : 36'h0, dd, bw_n);
        writes_exp++;
    endtask
    // Read lands four edges after sampling; the checks follow one edge later
    task automatic rd(input logic [14:0] ad, input logic proc);
        drive(!proc, proc, 1'b1, 4'hF, ad, rnd36());
        idle(5);
        check("read word", ref_mem[ad], {parity_out, data_out});
        check("drivers", {{4{parity_output_off}}, 32'h0}, {parity_oe_n, data_oe_n});
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        cmd = '0;
        {cmd.secondary_select, cmd.byte_write_n} = 5'h1F;
        {cmd.processor_address_strobe_n, cmd.controller_address_strobe_n} = 2'h3;
        cmd.burst_step_n = 1'b1;
        void'($urandom(25));
        repeat (12) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check("reset drivers", 36'hFFFFFFFFF, {parity_oe_n, data_oe_n});
        check("reset status", 36'h0, {34'h0, active, write_done});
        idle(1);
        $display("Test reset done");
        // Full words over one aligned group and loose words, then masked writes
        g = 15'($urandom) & 15'h7FFC;
        for (int i = 0; i < 8; i++) begin
            a = (i < 4) ? (g | 15'(i)) : 15'($urandom);
            used.push_back(a);
            wr(a, rnd36(), 4'h0);
        end
        for (int i = 0; i < 12; i++) begin
            wr(used[$urandom_range(7, 0)], rnd36(), 4'($urandom_range(14, 0)));
        end
        idle(8);
        check("write pulses", 36'(writes_exp), 36'(writes_seen));
        foreach (used[i]) rd(used[i], i[0]);
        $display("Test writes done");
        // Burst read; external address on the beats is noise
        a = g | 15'($urandom_range(3, 0));
        drive(1'b0, 1'b1, 1'b1, 4'hF, a, rnd36());
        for (int j = 1; j < 4; j++) drive(1'b1, 1'b1, 1'b0, 4'hF, 15'($urandom), rnd36());
        // First word stands one edge after the last beat is sampled
        idle(1);
        for (int j = 0; j < 4; j++) begin
            check("burst read", ref_mem[beat(a, j)], {parity_out, data_out});
            idle(1);
        end
        // Burst write continuing from the loaded address
        a = g | 15'($urandom_range(3, 0));
        wr(a, rnd36(), 4'h0);
        for (int j = 1; j < 4; j++) begin
            d = rnd36();
            drive(1'b1, 1'b1, 1'b0, 4'h0, 15'($urandom), d);
            ref_mem[beat(a, j)] = d;
            writes_exp++;
        end
        idle(8);
        check("write pulses", 36'(writes_exp), 36'(writes_seen));
        for (int j = 0; j < 4; j++) rd(beat(a, j), 1'b0);
        $display("Test burst done");
        // Processor strobe with lanes low reads; loading write with step low is dropped
        a = used[5];
        drive(1'b0, 1'b1, 1'b1, 4'h0, a, rnd36());
        idle(5);
        check("strobe read", ref_mem[a], {parity_out, data_out});
        drive(1'b1, 1'b0, 1'b0, 4'h0, a, rnd36());
        idle(8);
        check("write pulses", 36'(writes_exp), 36'(writes_seen));
        rd(a, 1'b1);
        $display("Test refused done");
        // Every enable combination; only one selects
        for (int c = 0; c < 8; c++) begin
            {cmd.primary_select_n, cmd.secondary_select, cmd.secondary_select_n} = 3'(c);
            a = used[c];
            d = rnd36();
            drive(1'b1, 1'b0, 1'b1, 4'h0, a, d);
            if (c == 2) begin
                ref_mem[a] = d;
                writes_exp++;
            end
            idle(8);
            check("active", {35'h0, c == 2}, {35'h0, active});
            check("write pulses", 36'(writes_exp), 36'(writes_seen));
        end
        {cmd.primary_select_n, cmd.secondary_select, cmd.secondary_select_n} = 3'b010;
        foreach (used[i]) rd(used[i], 1'b0);
        $display("Test select done");
        // Parity drivers off and back on
        parity_output_off = 1'b1;
        idle(4);
        rd(used[1], 1'b1);
        parity_output_off = 1'b0;
        idle(4);
        rd(used[1], 1'b0);
        $display("Test parity done");
        final_report();
    end
endmodule
`default_nettype wire
